/* File: src/pvs_bitclk.sv */
/*
  bit clock source of the pcm port: as master divides pclk down to the
  selected bit clock, as slave synchronises the external clock, sync and
  data pins and finds the bit clock edges.
  assumes pclk at 40 MHz and an external bit clock phase of >= 2 pclk.
*/
`include "pvs_defs.svh"
`default_nettype none

module pvs_bitclk
  import pvs_pkg::*;
#(
  parameter int HW = 8
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // mode
  input wire logic master,
  input wire logic run,
  input wire logic [1:0] rate,
  // pins
  input wire logic bclk_pin,
  input wire logic sync_pin,
  input wire logic din_pin,
  // results
  output logic bclk,
  output logic rise,
  output logic fall,
  output logic sync_lvl,
  output logic din_lvl
);
  localparam logic [HW-1:0] HALF0 = HW'(`PVS_PCLK_KHZ / (2 * `PVS_BCLK0_KHZ) - 1);
  localparam logic [HW-1:0] HALF1 = HW'(`PVS_PCLK_KHZ / (2 * `PVS_BCLK1_KHZ) - 1);
  localparam logic [HW-1:0] HALF2 = HW'(`PVS_PCLK_KHZ / (2 * `PVS_BCLK2_KHZ) - 1);

  logic [HW-1:0] cnt;
  logic [HW-1:0] hi;
  logic [1:0] rate_r;
  logic b1, b2, b3, s1, s2, d1, d2;

  wire gen = master & run;
  wire [HW-1:0] reload = (rate == 2'h2) ? HALF2 : (rate == 2'h1) ? HALF1 : HALF0;
  wire tick = gen & (cnt == '0);
  // slave edges compare the second and third stages, up to 4.096 MHz input
  wire ext_rise = b2 & ~b3;
  wire ext_fall = ~b2 & b3;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      {b1, b2, b3, s1, s2, d1, d2} <= 7'h00;
      {sync_lvl, din_lvl, bclk, rise, fall} <= 5'h00;
      cnt <= '0;
    end else begin
      b1 <= bclk_pin;
      b2 <= b1;
      b3 <= b2;
      s1 <= sync_pin;
      s2 <= s1;
      d1 <= din_pin;
      d2 <= d1;
      sync_lvl <= s2;
      din_lvl <= d2;
      cnt <= tick | ~gen ? reload : cnt - 1'b1;
      bclk <= gen & (tick ? ~bclk : bclk);
      rise <= gen ? tick & ~bclk : run & ext_rise;
      fall <= gen ? tick & bclk : run & ext_fall;
    end
  end

  // high-phase length, read only by the check below
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hi <= '0;
      rate_r <= 2'h0;
    end else begin
      hi <= bclk ? hi + 1'b1 : '0;
      rate_r <= rise ? rate : rate_r;
    end
  end

  a_half_high: assert property (@(posedge pclk) disable iff (!presetn)
    gen && $past(gen) && $fell(bclk) && rate == rate_r |-> hi == reload + 1'b1)
    else $error("master bit clock high phase has wrong length");

  a_slave_edge: assert property (@(posedge pclk) disable iff (!presetn)
    !master && run && b2 && !b3 |=> rise)
    else $error("slave bit clock rise not reported");

endmodule : pvs_bitclk

`default_nettype wire

/* File: src/pvs_defs.svh */
/*
  constants of the pcm voice serial port: clock rates, frame timing,
  register offsets, field positions and reset values.
  assumes it is included by its bare name wherever these are needed.
*/
`ifndef PVS_DEFS_SVH
`define PVS_DEFS_SVH

// clock rates in kHz
`define PVS_PCLK_KHZ 40000
`define PVS_BCLK0_KHZ 128
`define PVS_BCLK1_KHZ 256
`define PVS_BCLK2_KHZ 512
`define PVS_FRAME_KHZ 8
`define PVS_SLV_MIN_KHZ 64
`define PVS_SLV_MAX_KHZ 2048
`define PVS_GCI_MAX_KHZ 4096

// frame timing in bit clock periods
`define PVS_LSYNC_BITS 8
`define PVS_LAST0 6'h0f
`define PVS_LAST1 6'h1f
`define PVS_LAST2 6'h3f

// register byte offsets
`define PVS_OFS_CTRL 8'h00
`define PVS_OFS_CHCFG 8'h04
`define PVS_OFS_STAT 8'h08
`define PVS_OFS_TX0 8'h0c
`define PVS_OFS_RX0 8'h18
`define PVS_NCH 3

// control fields
`define PVS_CTRL_W 18
`define PVS_CTRL_EN 0
`define PVS_CTRL_MASTER 1
`define PVS_CTRL_FRAME 2
`define PVS_CTRL_RATE 4
`define PVS_CTRL_SLOT16 6
`define PVS_CTRL_FMT 7
`define PVS_CTRL_MSBF 9
`define PVS_CTRL_PAD 10
`define PVS_CTRL_ATT 12
`define PVS_CTRL_MUTE 15
`define PVS_CTRL_SFORCE 16
`define PVS_CTRL_RELF 17
`define PVS_CTRL_RST 18'h00000

// channel config: per channel enable then 2-bit slot
`define PVS_CHCFG_W 12
`define PVS_CHCFG_STRIDE 4
`define PVS_CHCFG_RST 12'h000

// status fields
`define PVS_STAT_RXN 0
`define PVS_STAT_TXD 4
`define PVS_STAT_POS 8

`endif

/* File: src/pvs_pkg.sv */
/*
  types of the pcm voice serial port.
  assumes nothing beyond a systemverilog compiler.
*/
`default_nettype none

package pvs_pkg;
  typedef enum logic [1:0] {pvs_fr_long, pvs_fr_short, pvs_fr_gci, pvs_fr_rsvd} pvs_frame_t;
  typedef enum logic [1:0] {pvs_lin13, pvs_lin16, pvs_mulaw, pvs_alaw} pvs_fmt_t;
  typedef enum logic [1:0] {pvs_pad_sign, pvs_pad_zero, pvs_pad_att, pvs_pad_rsvd} pvs_pad_t;
endpackage : pvs_pkg

`default_nettype wire

/* File: src/pvs_top.sv */
/*
  pcm voice serial port with an apb register slave: master or slave bit
  clock and frame sync, long, short and gci framing, three channels in
  the first four slots, 8 or 16 clock slots.
  assumes an apb master on pclk and pin buffers resolving the enables.
*/
// The address map and register access over APB were left to the implementer.
//
// Contract
// - as master the port drives bit clock and frame sync itself.
// - master bit clock selectable as 128, 256 or 512 kHz.
// - slave accepts an external bit clock up to 2048 kHz.
// - up to three channels, each in any of the first four slots.
// - long frame sync rising edge marks the word start.
// - master long frame sync stays high eight bit clock periods.
// - short sync falling edge marks word start, pulse one bit period.
// - input sampled on bit clock fall, output launched on rise.
// - output released after slot last bit, on that fall or next rise.
// - gci mode carries two 64 kbps b channels as two 8-bit slots.
// - gci frames start on sync rise at 8 kHz, slave clock to 4.096 MHz.
// - slots are 8 or 16 clocks; 8-clock slots only for 8-bit samples (not checked against fmt: linear words send their low byte).
// - formats 13-bit and 16-bit linear, 8-bit mu-law or a-law, 8 kHz.
// - bit order selectable as little or big endian.
// - unused slot bits padded with sign, zeros or 3-bit attenuation.
// - mute drives zeros on the serial output.
// - master may force frame sync low while the bit clock runs.
`include "pvs_defs.svh"
`default_nettype none

module pvs_top
  import pvs_pkg::*;
(
  // apb slave
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // bit clock pin
  input wire logic bclk_in,
  output logic bclk_out,
  output logic bclk_oe,
  // frame sync pin
  input wire logic sync_in,
  output logic sync_out,
  output logic sync_oe,
  // serial data pins
  input wire logic din,
  output logic dout,
  output logic dout_oe
);
  logic [`PVS_CTRL_W-1:0] ctrl;
  logic [`PVS_CHCFG_W-1:0] chcfg;
  logic [15:0] tx [`PVS_NCH];
  logic [15:0] rx [`PVS_NCH];
  logic [`PVS_NCH-1:0] rx_new, tx_done;
  logic [5:0] pos;
  logic [15:0] rx_acc;
  logic sync_d, launch_d, past_end;
  logic bit_rise, bit_fall, sync_s, din_s;

  // decoded control
  wire run = ctrl[`PVS_CTRL_EN];
  wire master = ctrl[`PVS_CTRL_MASTER];
  wire [1:0] rate = ctrl[`PVS_CTRL_RATE +: 2];
  wire pvs_frame_t frame = pvs_frame_t'(ctrl[`PVS_CTRL_FRAME +: 2]);
  wire pvs_fmt_t fmt = pvs_fmt_t'(ctrl[`PVS_CTRL_FMT +: 2]);
  wire pvs_pad_t pad = pvs_pad_t'(ctrl[`PVS_CTRL_PAD +: 2]);
  wire [2:0] att = ctrl[`PVS_CTRL_ATT +: 3];
  wire msbf = ctrl[`PVS_CTRL_MSBF];
  wire mute = ctrl[`PVS_CTRL_MUTE];
  wire sforce = ctrl[`PVS_CTRL_SFORCE];
  wire relf = ctrl[`PVS_CTRL_RELF];
  wire short_fs = (frame == pvs_fr_short);
  wire gci = (frame == pvs_fr_gci);

  pvs_bitclk #(.HW(8)) u_bitclk (
    .pclk(pclk),
    .presetn(presetn),
    .master(master),
    .run(run),
    .rate(rate),
    .bclk_pin(bclk_in),
    .sync_pin(sync_in),
    .din_pin(din),
    .bclk(bclk_out),
    .rise(bit_rise),
    .fall(bit_fall),
    .sync_lvl(sync_s),
    .din_lvl(din_s)
  );

  // frame position; only the sync edge counts, so any long pulse width works
  wire start = run & ~master & (short_fs ? sync_d & ~sync_s : sync_s & ~sync_d);
  wire launch = bit_rise | start;
  wire [5:0] last_pos = (rate == 2'h2) ? `PVS_LAST2 : (rate == 2'h1) ? `PVS_LAST1 : `PVS_LAST0;
  wire [5:0] pos_inc = pos + 6'h01;
  wire [5:0] next_pos = master ? (bit_rise ? (pos == last_pos ? 6'h00 : pos_inc) : pos)
                      : start ? 6'h00 : (bit_rise && pos != 6'h3f) ? pos_inc : pos;
  // slave frames longer than four 16-clock slots: nothing is driven past them
  wire next_past_end = ~master & ~start & (past_end | (bit_rise & pos == 6'h3f));
  wire next_sync = master & run & ~sforce
                 & (bit_rise ? (short_fs ? next_pos == last_pos
                                         : next_pos < `PVS_LSYNC_BITS)
                             : sync_out);

  // slot decode: gci uses the first two 8-clock slots only
  wire eff16 = ctrl[`PVS_CTRL_SLOT16] & ~gci;
  wire [1:0] cur_slot = eff16 ? pos[5:4] : pos[4:3];
  wire in_win = ~past_end & (eff16 | (gci ? pos[5:4] == 2'h0 : ~pos[5]));
  wire [3:0] idx = eff16 ? pos[3:0] : {1'b0, pos[2:0]};
  wire [3:0] last_idx = eff16 ? 4'hf : 4'h7;
  wire last_bit = (idx == last_idx);
  wire [3:0] tidx = msbf ? last_idx - idx : idx;
  wire [`PVS_NCH-1:0] hit;

  for (genvar k = 0; k < `PVS_NCH; k++) begin : g_hit
    wire en = chcfg[k * `PVS_CHCFG_STRIDE];
    wire [1:0] slot = chcfg[k * `PVS_CHCFG_STRIDE + 1 +: 2];
    assign hit[k] = run & en & in_win & (slot == cur_slot);
  end

  function automatic logic [1:0] pvs_first(input logic [`PVS_NCH-1:0] h);
    pvs_first = h[0] ? 2'h0 : h[1] ? 2'h1 : 2'h2;
  endfunction : pvs_first

  // sample right-aligned, pad above it; 8-clock slots use the low byte
  function automatic logic [15:0] pvs_slot_word(input logic [15:0] s, input pvs_fmt_t f,
                                                input pvs_pad_t p, input logic [2:0] a);
    logic [15:0] w;
    w = s;
    if (f == pvs_lin13) begin
      w[15:13] = (p == pvs_pad_sign) ? {3{s[12]}} : (p == pvs_pad_att) ? a : 3'h0;
    end else if (f != pvs_lin16) begin
      w[15:8] = (p == pvs_pad_sign) ? {8{s[7]}} : (p == pvs_pad_att) ? {a, 5'h00} : 8'h00;
    end
    return w;
  endfunction : pvs_slot_word

  wire hit_any = |hit;
  wire [1:0] sel = pvs_first(hit);
  wire [15:0] word = pvs_slot_word(tx[sel], fmt, pad, att);
  wire out_bit = word[tidx];
  wire [15:0] onehot = 16'h0001 << tidx;
  wire [15:0] assembled = (rx_acc & ~onehot) | (din_s ? onehot : 16'h0000);
  wire slot_end = bit_fall & hit_any & last_bit;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pos <= 6'h00;
      {sync_d, launch_d, sync_out, bclk_oe, sync_oe} <= 5'h00;
      past_end <= 1'b0;
    end else begin
      pos <= next_pos;
      past_end <= next_past_end;
      sync_d <= sync_s;
      launch_d <= launch;
      sync_out <= next_sync;
      bclk_oe <= master & run;
      sync_oe <= master & run;
    end
  end

  // serial output, launched after the rising edge; release as configured
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dout <= 1'b0;
      dout_oe <= 1'b0;
    end else if (!run) begin
      dout <= 1'b0;
      dout_oe <= 1'b0;
    end else if (launch_d) begin
      dout <= hit_any & ~mute & out_bit;
      dout_oe <= hit_any;
    end else if (relf && slot_end) begin
      dout_oe <= 1'b0;
    end
  end

  // receive on the falling edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_acc <= 16'h0000;
    end else if (bit_fall && hit_any) begin
      rx_acc <= assembled;
    end
  end

  // apb decode
  function automatic logic [2:0] pvs_chan_dec(input logic [7:0] a, input logic [7:0] base);
    logic [7:0] d;
    d = a - base;
    pvs_chan_dec = {(a >= base) && (d[1:0] == 2'h0) && (d[7:2] < `PVS_NCH), d[3:2]};
  endfunction : pvs_chan_dec

  wire [2:0] tx_dec = pvs_chan_dec(paddr, `PVS_OFS_TX0);
  wire [2:0] rx_dec = pvs_chan_dec(paddr, `PVS_OFS_RX0);
  wire hit_ctrl = (paddr == `PVS_OFS_CTRL);
  wire hit_chcfg = (paddr == `PVS_OFS_CHCFG);
  wire hit_stat = (paddr == `PVS_OFS_STAT);
  wire acc = psel & penable & ~pready;
  wire wr_en = psel & penable & pready & pwrite;
  wire wr_ok = wr_en & ~pslverr;
  logic [31:0] rd_word;
  logic bad;

  always_comb begin
    rd_word = 32'h0000_0000;
    bad = 1'b0;
    if (hit_ctrl) begin
      rd_word[`PVS_CTRL_W-1:0] = ctrl;
    end else if (hit_chcfg) begin
      rd_word[`PVS_CHCFG_W-1:0] = chcfg;
    end else if (hit_stat) begin
      rd_word[`PVS_STAT_RXN +: `PVS_NCH] = rx_new;
      rd_word[`PVS_STAT_TXD +: `PVS_NCH] = tx_done;
      rd_word[`PVS_STAT_POS +: 6] = pos;
    end else if (tx_dec[2]) begin
      rd_word[15:0] = tx[tx_dec[1:0]];
    end else if (rx_dec[2]) begin
      rd_word[15:0] = rx[rx_dec[1:0]];
      bad = pwrite;
    end else begin
      bad = 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      pready <= acc;
      pslverr <= acc & bad;
      prdata <= (acc && !pwrite && !bad) ? rd_word : 32'h0000_0000;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl <= `PVS_CTRL_RST;
      chcfg <= `PVS_CHCFG_RST;
    end else if (wr_ok && hit_ctrl) begin
      ctrl <= pwdata[`PVS_CTRL_W-1:0];
    end else if (wr_ok && hit_chcfg) begin
      chcfg <= pwdata[`PVS_CHCFG_W-1:0];
    end
  end

  // per channel data and sticky flags; a set in the clearing cycle wins
  for (genvar k = 0; k < `PVS_NCH; k++) begin : g_ch
    wire done = slot_end & (sel == 2'(k));
    wire clr = wr_ok & hit_stat;
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        tx[k] <= 16'h0000;
        rx[k] <= 16'h0000;
        rx_new[k] <= 1'b0;
        tx_done[k] <= 1'b0;
      end else begin
        if (wr_ok && tx_dec == {1'b1, 2'(k)}) begin
          tx[k] <= pwdata[15:0];
        end
        if (done) begin
          rx[k] <= eff16 ? assembled : {8'h00, assembled[7:0]};
        end
        rx_new[k] <= done | (rx_new[k] & ~(clr & pwdata[`PVS_STAT_RXN + k]));
        tx_done[k] <= done | (tx_done[k] & ~(clr & pwdata[`PVS_STAT_TXD + k]));
      end
    end
  end

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  a_master_pins: assert property (run && master |=> bclk_oe && sync_oe)
    else $error("master does not drive clock and sync");
  a_sync_force: assert property (run && master && sforce |=> !sync_out)
    else $error("forced sync is not low");
  a_long_sync: assert property (bit_rise && run && master && !sforce && !short_fs
    |=> sync_out == (pos < `PVS_LSYNC_BITS))
    else $error("long sync width wrong");
  a_short_sync: assert property (bit_rise && run && master && !sforce && short_fs
    |=> sync_out == (pos == $past(last_pos)))
    else $error("short sync not one period before word");
  a_long_start: assert property (run && !master && !short_fs && $rose(sync_s) |=> pos == 6'h00)
    else $error("long sync rise did not start the word");
  a_out_launch: assert property ($past(run) && run && $changed(dout) |-> $past(launch_d))
    else $error("output changed away from a launch");
  a_rx_fall: assert property ($rose(rx_new[0]) |-> $past(bit_fall))
    else $error("receive completed without a falling edge");
  a_rel_fall: assert property (run && relf && slot_end && !launch_d |=> !dout_oe)
    else $error("output not released on last bit fall");
  a_mute_zero: assert property (run && launch_d && mute |=> !dout)
    else $error("muted output not zero");
  a_slot_idle: assert property (run && launch_d && !hit_any |=> !dout_oe)
    else $error("output driven outside a chosen slot");
  a_gci_window: assert property (run && launch_d && gci && pos >= 6'h10 |=> !dout_oe)
    else $error("gci output beyond two b channels");
  a_pad_zero: assert property (run && launch_d && hit_any && eff16 && msbf && fmt == pvs_lin13
    && pad == pvs_pad_zero && idx < 4'h3 |=> !dout)
    else $error("zero padding not zero");

  c_master_long: cover property (run && master && !short_fs && $rose(sync_out));
  c_slave_short: cover property (start && short_fs);
  c_rx_done: cover property (slot_end && eff16);
  c_mute: cover property (launch_d && mute && hit_any);

endmodule : pvs_top

`default_nettype wire

/* File: tb/pvs_codec.sv */
/*
  far-side pcm codec model: makes the bit clock and frame sync when the
  port is slave, captures the serial output and answers on the input.
  assumes the bench resolves every pin from both parties' enables.
*/
`default_nettype none

module pvs_codec #(
  parameter int HALF_NS = 250,
  parameter int FRAME = 250
) (
  // mode
  input wire logic drv,
  input wire logic short_sync,
  input wire logic [63:0] txw,
  // resolved pins
  input wire logic bclk,
  input wire logic sync,
  input wire logic dout,
  input wire logic dout_oe,
  // driven pins
  output logic bclk_drv,
  output logic sync_drv,
  output logic din,
  // last whole frame seen
  output logic [63:0] word,
  output logic [15:0] frames,
  output logic [7:0] nsync,
  output logic [7:0] noe
);
  timeunit 1ns;
  timeprecision 1ps;
  int g = 0;
  int pos = 1000;
  logic ps = 1'b0;
  logic [63:0] cap = '0;
  logic [7:0] cs = '0;
  logic [7:0] co = '0;

  // free-running clock while slave, 2 MHz, idle low (pull-down) otherwise
  initial begin
    {bclk_drv, sync_drv, din} = '0;
    {word, frames, nsync, noe} = '0;
    #7;
    forever begin
      #(HALF_NS);
      bclk_drv = drv ? !bclk_drv : 1'b0;
    end
  end

  always @(posedge bclk_drv) begin
    g <= (g == FRAME - 1) ? 0 : g + 1;
    sync_drv <= short_sync ? (g == FRAME - 2) : (g == FRAME - 1 || g < 7);
  end

  always @(negedge bclk) begin
    if (short_sync ? (ps && !sync) : (sync && !ps)) begin
      word <= cap;
      frames <= frames + 16'd1;
      nsync <= cs;
      noe <= co;
      cs <= {7'h0, sync};
      co <= {7'h0, dout_oe};
      cap[0] <= dout;
      pos <= 0;
    end else begin
      if (pos < 63) cap[pos + 1] <= dout;
      cs <= cs + {7'h0, sync};
      co <= co + {7'h0, dout_oe};
      pos <= pos + 1;
    end
    ps <= sync;
  end

  // input released to the pull-down level after the captured span
  always @(posedge bclk) begin
    if (pos < 63) din <= txw[pos + 1];
    else if (pos == 63) din <= 1'b0;
  end

  always @(posedge sync) if (!short_sync) din <= txw[0];
  always @(negedge sync) if (short_sync) din <= txw[0];
endmodule : pvs_codec

`default_nettype wire

/* File: tb/tb.sv */
/*
  bench of the pcm voice serial port: apb tasks and a table of framing
  cases, each checked against what the codec model saw on the wire.
  assumes pvs_top and pvs_codec are compiled before it.
*/
`default_nettype none
`include "pvs_defs.svh"
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin miscompares++; \
  $display("BAD %s expected %h seen %h", nm, e, g); end end

module tb
  import pvs_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {
    logic m; pvs_frame_t fr; logic [1:0] rt; logic s16; pvs_fmt_t fmt; logic msb;
    pvs_pad_t pad; logic [2:0] att; logic [1:0] ext; logic [1:0] slot; logic [15:0] tx;
  } pvs_case_t;
  pvs_case_t cases [7] = '{
    '{1'b1, pvs_fr_long, 2'd2, 1'b0, pvs_mulaw, 1'b1, pvs_pad_sign, 3'd0, 2'd0, 2'd1, 16'h004b},
    '{1'b1, pvs_fr_short, 2'd1, 1'b1, pvs_lin13, 1'b0, pvs_pad_sign, 3'd0, 2'd0, 2'd1, 16'h1abc},
    '{1'b1, pvs_fr_long, 2'd2, 1'b1, pvs_lin13, 1'b1, pvs_pad_zero, 3'd0, 2'd1, 2'd3, 16'h1abc},
    '{1'b1, pvs_fr_long, 2'd0, 1'b1, pvs_mulaw, 1'b0, pvs_pad_att, 3'd5, 2'd0, 2'd0, 16'h0081},
    '{1'b0, pvs_fr_short, 2'd0, 1'b1, pvs_lin16, 1'b1, pvs_pad_sign, 3'd0, 2'd0, 2'd0, 16'h8001},
    '{1'b0, pvs_fr_long, 2'd0, 1'b1, pvs_alaw, 1'b0, pvs_pad_sign, 3'd0, 2'd2, 2'd2, 16'h0081},
    '{1'b0, pvs_fr_gci, 2'd0, 1'b0, pvs_alaw, 1'b0, pvs_pad_sign, 3'd0, 2'd0, 2'd1, 16'h00c3}};
  int khz [3] = '{`PVS_BCLK0_KHZ, `PVS_BCLK1_KHZ, `PVS_BCLK2_KHZ};
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = '0;
  logic [31:0] pwdata = '0;
  logic [31:0] prdata;
  logic pready, pslverr, bclk_out, bclk_oe, sync_out, sync_oe, dout, dout_oe;
  logic cdrv = 1'b0;
  logic cshort = 1'b0;
  logic cbclk, csync, din, pb;
  logic [63:0] ctx = 64'h5a3c_e10f_c396_7e81;
  logic [63:0] cword;
  logic [15:0] cframes;
  logic [7:0] cnsync, cnoe;
  wire logic bclk_w = bclk_oe ? bclk_out : cbclk;
  wire logic sync_w = sync_oe ? sync_out : csync;
  wire logic dout_w = dout_oe & dout; // released output reads as the pull-down
  int miscompares = 0;
  int checked = 0;
  int per = 0;
  int cnt = 0;

  pvs_top pvs_top_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .bclk_in(bclk_w), .bclk_out(bclk_out), .bclk_oe(bclk_oe),
    .sync_in(sync_w), .sync_out(sync_out), .sync_oe(sync_oe), .din(din), .dout(dout),
    .dout_oe(dout_oe));
  pvs_codec pvs_codec_i (.drv(cdrv), .short_sync(cshort), .txw(ctx), .bclk(bclk_w),
    .sync(sync_w), .dout(dout_w), .dout_oe(dout_oe), .bclk_drv(cbclk), .sync_drv(csync),
    .din(din), .word(cword), .frames(cframes), .nsync(cnsync), .noe(cnoe));

  initial begin
    forever #12.5 pclk = !pclk;
  end

  // pclk cycles between rises of the generated bit clock
  always @(posedge pclk) begin
    pb <= bclk_out;
    cnt <= (bclk_out && !pb) ? 1 : cnt + 1;
    if (bclk_out && !pb) per <= cnt;
  end

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] rd, output logic err);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic eerr);
    logic [31:0] rd;
    logic e;
    apb(1'b1, a, d, rd, e);
    `CHK("write error", eerr, e)
  endtask : wr

  task automatic rdchk(input string nm, input logic [7:0] a, input logic [31:0] exp,
                       input logic eerr);
    logic [31:0] rd;
    logic e;
    apb(1'b0, a, 32'h0, rd, e);
    `CHK(nm, exp, rd)
    `CHK("read error", eerr, e)
  endtask : rdchk

  function automatic logic [31:0] ctrl_of(pvs_case_t c);
    logic [31:0] v;
    v = 32'h1;
    v[`PVS_CTRL_MASTER] = c.m;
    v[`PVS_CTRL_FRAME +: 2] = c.fr;
    v[`PVS_CTRL_RATE +: 2] = c.rt;
    v[`PVS_CTRL_SLOT16] = c.s16;
    v[`PVS_CTRL_FMT +: 2] = c.fmt;
    v[`PVS_CTRL_MSBF] = c.msb;
    v[`PVS_CTRL_PAD +: 2] = c.pad;
    v[`PVS_CTRL_ATT +: 3] = c.att;
    v[`PVS_CTRL_MUTE] = c.ext[1];
    v[`PVS_CTRL_RELF] = c.ext[0];
    return v;
  endfunction : ctrl_of

  // slot bits in the order they cross the wire
  function automatic logic [15:0] slot_bits(pvs_case_t c);
    logic [15:0] w, top, t;
    int n;
    n = c.s16 ? 16 : 8;
    top = c.pad == pvs_pad_sign ? {16{c.fmt == pvs_lin13 ? c.tx[12] : c.tx[7]}}
        : c.pad == pvs_pad_att ? {c.att, 13'h0} : 16'h0;
    if (c.fmt == pvs_lin16) w = c.tx;
    else if (c.fmt == pvs_lin13) w = {top[15:13], c.tx[12:0]};
    else w = {c.s16 ? top[15:8] : 8'h0, c.tx[7:0]};
    if (c.ext[1]) w = 16'h0;
    t = 16'h0;
    for (int i = 0; i < n; i++) t[i] = c.msb ? w[n - 1 - i] : w[i];
    return t;
  endfunction : slot_bits

  function automatic logic [15:0] rx_bits(pvs_case_t c);
    logic [15:0] r;
    int n;
    n = c.s16 ? 16 : 8;
    r = 16'h0;
    for (int i = 0; i < n; i++) r[c.msb ? n - 1 - i : i] = ctx[c.slot * n + i];
    return r;
  endfunction : rx_bits

  task automatic force_sync(input logic [31:0] ctrl);
    int hi = 0;
    int rises = 0;
    wr(`PVS_OFS_CTRL, ctrl | (32'h1 << `PVS_CTRL_SFORCE), 1'b0);
    repeat (4) @(posedge pclk);
    repeat (3000) begin
      @(posedge pclk);
      hi += sync_out;
      rises += (bclk_out && !pb);
    end
    `CHK("forced sync", 32'h0, 32'(hi))
    `CHK("clock runs", 1'b1, rises > 30)
  endtask : force_sync

  task automatic finish_test;
    $display("comparisons %0d mismatches %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : finish_test

  initial begin
    // seven cases of at most three 125 us frames each, plus the forced-sync span
    #3000000;
    miscompares++;
    finish_test();
  end

  initial begin
    pvs_case_t c;
    logic [31:0] ctrl, chcfg;
    logic [7:0] ofs;
    logic [15:0] f;
    int n, base;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    `CHK("idle pins", 3'b000, {bclk_oe, sync_oe, dout_oe})
    rdchk("ctrl reset", `PVS_OFS_CTRL, 32'h0, 1'b0);
    rdchk("chcfg reset", `PVS_OFS_CHCFG, 32'h0, 1'b0);
    wr(`PVS_OFS_RX0, 32'hffff, 1'b1);
    rdchk("rx read only", `PVS_OFS_RX0, 32'h0, 1'b0);
    rdchk("unmapped", 8'h40, 32'h0, 1'b1);
    for (int i = 0; i < 7; i++) begin
      c = cases[i];
      ctrl = ctrl_of(c);
      ofs = 8'(4 * (i % 3));
      n = c.s16 ? 16 : 8;
      base = c.slot * n;
      chcfg = 32'h0;
      chcfg[4 * (i % 3) +: 3] = {c.slot, 1'b1};
      cdrv <= !c.m;
      cshort <= c.fr == pvs_fr_short;
      wr(`PVS_OFS_TX0 + ofs, {16'h0, c.tx}, 1'b0);
      rdchk("tx readback", `PVS_OFS_TX0 + ofs, {16'h0, c.tx}, 1'b0);
      wr(`PVS_OFS_CHCFG, chcfg, 1'b0);
      wr(`PVS_OFS_CTRL, ctrl, 1'b0);
      f = cframes;
      wait (cframes == f + 16'd3);
      `CHK("slot bits", slot_bits(c), cword[base +: 16])
      `CHK("driven bits", 8'(n), cnoe)
      rdchk("rx sample", `PVS_OFS_RX0 + ofs, {16'h0, rx_bits(c)}, 1'b0);
      if (c.m) begin
        `CHK("pins driven", 2'b11, {bclk_oe, sync_oe})
        `CHK("bit period", 32'(2 * (`PVS_PCLK_KHZ / (2 * khz[c.rt]))), 32'(per))
        `CHK("sync bits", c.fr == pvs_fr_short ? 8'd1 : 8'(`PVS_LSYNC_BITS), cnsync)
      end
      if (i == 0) force_sync(ctrl);
    end
    finish_test();
  end
endmodule : tb

`default_nettype wire
